// [crcc_defs.vh]
// Constants for the caller and codec channel control block
`ifndef CRCC_DEFS_VH
`define CRCC_DEFS_VH
// Clock rate in kHz
`define CRCC_CLK_KHZ 100000
// Talkback flash after remote talk, in ms
`define CRCC_FLASH_MS 3000
// Flash cycle count: flash time times clock rate, sized to the counter
`define CRCC_FLASH_CYC 29'h11E1A300
// Half period of the flashing key, in ms
`define CRCC_BLINK_MS 250
// Blink half period in cycles, sized to the counter
`define CRCC_BLINK_CYC 29'h17D7840
// Debounce settle time, in ms
`define CRCC_DEB_MS 5
// Debounce settle time in cycles, sized to the counter
`define CRCC_DEB_CYC 29'h007A120
// Counter width for the long counts
`define CRCC_CW 29
// Return feed source codes
`define CRCC_SRC_PGM1 3'h0
`define CRCC_SRC_PGM2 3'h1
`define CRCC_SRC_PGM3 3'h2
`define CRCC_SRC_PGM4 3'h3
`define CRCC_SRC_TB 3'h4
`define CRCC_SRC_OFF 3'h7
// Status display codes
`define CRCC_DISP_BLANK 3'h0
`define CRCC_DISP_PGM 3'h1
`define CRCC_DISP_TB 3'h2
`define CRCC_DISP_TALK 3'h3
`define CRCC_DISP_MUTE 3'h4
// Feed mode codes: automatic or fixed bus
`define CRCC_MODE_AUTO 3'h4
// Remote command inputs
`define CRCC_NCMD 6
`define CRCC_CMD_ON 0
`define CRCC_CMD_OFF 1
`define CRCC_CMD_PREV 2
`define CRCC_CMD_TALK 3
`define CRCC_CMD_MUTE 4
`define CRCC_CMD_SEL2 5
// Avalon register offsets, byte addresses
`define CRCC_REG_CTRL 4'h0
`define CRCC_REG_STAT 4'h4
`define CRCC_REG_IRQ 4'h8
`define CRCC_REG_MASK 4'hC
// Control fields
`define CRCC_CTL_CODEC 0
`define CRCC_CTL_MODE_LO 1
`define CRCC_CTL_MODE_HI 3
`define CRCC_CTL_LOCAL_ON 4
`define CRCC_CTL_LOCAL_OFF 5
`define CRCC_CTL_PRGM2 6
`define CRCC_CTL_PULSE_EN 7
// Interrupt event bits
`define CRCC_NIRQ 4
`define CRCC_IRQ_ON 0
`define CRCC_IRQ_OFF 1
`define CRCC_IRQ_TALK 2
`define CRCC_IRQ_MUTE 3
`endif

// [crcc_sync_deb.v]
// Two-flop synchroniser followed by a debouncer for one input
`timescale 1ns/1ps
`include "crcc_defs.vh"
module crcc_sync_deb #(
	parameter [`CRCC_CW-1:0] SETTLE = `CRCC_DEB_CYC
) (
	input wire clock,
	input wire srst,
	input wire pinIn,
	output reg level
);
	reg meta_q;
	reg sync_q;
	reg [`CRCC_CW-1:0] cnt_q;
	// Two flops; only sync_q is read by logic
	always @(posedge clock) begin
		if (srst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
		end
	end
	// Level changes only after a steady settle time
	always @(posedge clock) begin
		if (srst) begin
			cnt_q <= {`CRCC_CW{1'b0}};
			level <= 1'b0;
		end else if (sync_q == level) begin
			cnt_q <= {`CRCC_CW{1'b0}};
		end else if (cnt_q >= SETTLE - 1'b1) begin
			cnt_q <= {`CRCC_CW{1'b0}};
			level <= sync_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // crcc_sync_deb

// [crcc_flash.v]
// Timed flasher for the talkback key after remote talk ends
`timescale 1ns/1ps
`include "crcc_defs.vh"
module crcc_flash #(
	parameter [`CRCC_CW-1:0] DUR = `CRCC_FLASH_CYC,
	parameter [`CRCC_CW-1:0] HALF = `CRCC_BLINK_CYC
) (
	input wire clock,
	input wire srst,
	input wire start,
	output reg active,
	output reg blink
);
	reg [`CRCC_CW-1:0] durCnt_q;
	reg [`CRCC_CW-1:0] halfCnt_q;
	// Restart wins over a running flash
	always @(posedge clock) begin
		if (srst) begin
			active <= 1'b0;
			blink <= 1'b0;
			durCnt_q <= {`CRCC_CW{1'b0}};
			halfCnt_q <= {`CRCC_CW{1'b0}};
		end else if (start) begin
			active <= 1'b1;
			blink <= 1'b1;
			durCnt_q <= {`CRCC_CW{1'b0}};
			halfCnt_q <= {`CRCC_CW{1'b0}};
		end else if (active) begin
			durCnt_q <= durCnt_q + 1'b1;
			if (durCnt_q >= DUR - 1'b1) begin
				// Key left dark at the end, ready for the next flash
				active <= 1'b0;
				blink <= 1'b0;
			end else if (halfCnt_q >= HALF - 1'b1) begin
				halfCnt_q <= {`CRCC_CW{1'b0}};
				blink <= ~blink;
			end else begin
				halfCnt_q <= halfCnt_q + 1'b1;
			end
		end
	end
endmodule // crcc_flash

// [crcc_channel.v]
// Caller or codec channel control with Avalon-MM registers
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "crcc_defs.vh"
module crcc_channel #(
	parameter [`CRCC_CW-1:0] DEB_CYC = `CRCC_DEB_CYC,
	parameter [`CRCC_CW-1:0] FLASH_CYC = `CRCC_FLASH_CYC,
	parameter [`CRCC_CW-1:0] BLINK_CYC = `CRCC_BLINK_CYC
) (
	input wire clock,
	input wire srst,
	input wire [3:0] avsAddress,
	input wire avsRead,
	input wire avsWrite,
	input wire [31:0] avsWriteData,
	input wire [3:0] avsByteEnable,
	output reg [31:0] avsReadData,
	output reg avsWaitRequest,
	output reg avsResponse,
	input wire [`CRCC_NCMD-1:0] remoteCmd,
	input wire operatorTalk,
	output reg onLamp,
	output reg offLamp,
	output reg previewLamp,
	output reg onStatus,
	output reg startPulse,
	output reg stopPulse,
	output reg talkbackKey,
	output reg [2:0] statusDisplay,
	output reg [2:0] feedLeftSel,
	output reg [2:0] feedRightSel,
	output reg feedMinusSelf,
	output reg outputsMuted,
	output reg sourceToTalkback,
	output reg irq
);
	// Control fields held by software
	// Control register layout:
	// bit 0 codec channel when set, caller when clear
	// bits 3:1 feed mode: fixed bus code, or the auto code
	// bit 4 local on strobe, not applied again later
	// bit 5 local off strobe; off wins a tie with on
	// bit 6 codec feed takes program two
	// bit 7 start and stop pulses enabled
	// Status word: bit 0 on, bit 1 muted, bit 2 key,
	// bits 5:3 display code
	reg [7:0] ctrl_q;
	reg [`CRCC_NIRQ-1:0] irqStat_q;
	reg [`CRCC_NIRQ-1:0] irqMask_q;
	reg chanOn_q;
	reg talkPrev_q;
	reg mutePrev_q;
	reg onPrev_q;
	reg localOnReq;
	reg localOffReq;
	reg busy_q;
	wire [`CRCC_NCMD-1:0] cmd;
	wire flashActive;
	wire flashBlink;
	wire isCodec;
	wire [2:0] feedMode;
	wire talkAct;
	wire muteAct;
	wire talkEnd;
	wire [`CRCC_NIRQ-1:0] events;
	wire accept;
	wire wrAccept;
	wire selCtrl;
	wire selStat;
	wire selIrq;
	wire selMask;
	wire selNone;
	reg [2:0] leftSel_d;
	reg [2:0] rightSel_d;
	reg [2:0] disp_d;
	reg key_d;
	reg minus_d;
	genvar gi;

	assign isCodec = ctrl_q[`CRCC_CTL_CODEC];
	assign feedMode = ctrl_q[`CRCC_CTL_MODE_HI:`CRCC_CTL_MODE_LO];

	generate
		for (gi = 0; gi < `CRCC_NCMD; gi = gi + 1) begin : gSync
			crcc_sync_deb #(
				.SETTLE(DEB_CYC)
			) uSync (
				.clock(clock),
				.srst(srst),
				.pinIn(remoteCmd[gi]),
				.level(cmd[gi])
			);
		end
	endgenerate

	// Talk and mute only apply to codec channels
	assign talkAct = isCodec & cmd[`CRCC_CMD_TALK];
	assign muteAct = isCodec & cmd[`CRCC_CMD_MUTE];
	assign talkEnd = talkPrev_q & ~talkAct;

	crcc_flash #(
		.DUR(FLASH_CYC),
		.HALF(BLINK_CYC)
	) uFlash (
		.clock(clock),
		.srst(srst),
		.start(talkEnd),
		.active(flashActive),
		.blink(flashBlink)
	);

	// on/off from remote or software; off wins a tie
	// A held off pin therefore blocks a software turn-on
	always @(posedge clock) begin
		if (srst) begin
			chanOn_q <= 1'b0;
			talkPrev_q <= 1'b0;
			mutePrev_q <= 1'b0;
			onPrev_q <= 1'b0;
		end else begin
			if (cmd[`CRCC_CMD_OFF] | localOffReq) begin
				chanOn_q <= 1'b0;
			end else if (cmd[`CRCC_CMD_ON] | localOnReq) begin
				chanOn_q <= 1'b1;
			end
			talkPrev_q <= talkAct;
			mutePrev_q <= muteAct;
			onPrev_q <= chanOn_q;
		end
	end

	// Feed routing, display and key
	always @* begin
		leftSel_d = `CRCC_SRC_PGM1;
		rightSel_d = `CRCC_SRC_PGM1;
		disp_d = `CRCC_DISP_PGM;
		key_d = 1'b0;
		minus_d = 1'b0;
		if (isCodec) begin
			rightSel_d = ctrl_q[`CRCC_CTL_PRGM2] ? `CRCC_SRC_PGM2 : `CRCC_SRC_PGM1;
			leftSel_d = operatorTalk ? `CRCC_SRC_TB : rightSel_d;
			key_d = flashActive & flashBlink;
			if (talkAct) begin
				key_d = 1'b1;
				disp_d = `CRCC_DISP_TALK;
			end else if (muteAct) begin
				disp_d = `CRCC_DISP_MUTE;
			end
		end else if (feedMode == `CRCC_MODE_AUTO) begin
			if (chanOn_q) begin
				minus_d = 1'b1;
			end else begin
				leftSel_d = `CRCC_SRC_TB;
				rightSel_d = `CRCC_SRC_TB;
				key_d = 1'b1;
				disp_d = `CRCC_DISP_TB;
			end
		end else begin
			// fixed bus regardless of on/off
			// Codes above the auto code fold onto buses PGM2 to PGM4
			leftSel_d = {1'b0, feedMode[1:0]};
			rightSel_d = {1'b0, feedMode[1:0]};
		end
	end

	// Outputs registered; one feed per channel instance
	always @(posedge clock) begin
		if (srst) begin
			feedLeftSel <= `CRCC_SRC_OFF;
			feedRightSel <= `CRCC_SRC_OFF;
			feedMinusSelf <= 1'b0;
			statusDisplay <= `CRCC_DISP_BLANK;
			talkbackKey <= 1'b0;
			outputsMuted <= 1'b0;
			sourceToTalkback <= 1'b0;
			onLamp <= 1'b0;
			offLamp <= 1'b0;
			previewLamp <= 1'b0;
			onStatus <= 1'b0;
			startPulse <= 1'b0;
			stopPulse <= 1'b0;
		end else begin
			feedLeftSel <= leftSel_d;
			feedRightSel <= rightSel_d;
			feedMinusSelf <= minus_d;
			statusDisplay <= disp_d;
			talkbackKey <= key_d;
			outputsMuted <= talkAct | muteAct;
			sourceToTalkback <= talkAct;
			onLamp <= chanOn_q;
			offLamp <= ~chanOn_q;
			previewLamp <= ~isCodec & cmd[`CRCC_CMD_PREV];
			onStatus <= chanOn_q;
			startPulse <= ctrl_q[`CRCC_CTL_PULSE_EN] & chanOn_q & ~onPrev_q;
			stopPulse <= ctrl_q[`CRCC_CTL_PULSE_EN] & ~chanOn_q & onPrev_q;
		end
	end

	// Events for the sticky status
	// Edges come from registered state, so each fires once
	assign events[`CRCC_IRQ_ON] = chanOn_q & ~onPrev_q;
	assign events[`CRCC_IRQ_OFF] = ~chanOn_q & onPrev_q;
	assign events[`CRCC_IRQ_TALK] = talkAct & ~talkPrev_q;
	assign events[`CRCC_IRQ_MUTE] = muteAct & ~mutePrev_q;

	// Request taken when the slave is not still answering
	// the previous one; a back-to-back request still gets just one wait cycle
	assign accept = (avsRead | avsWrite) & ~busy_q;
	assign wrAccept = accept & avsWrite & avsByteEnable[0];

	// Address decode; only byte lane 0 carries register bits
	assign selCtrl = (avsAddress == `CRCC_REG_CTRL);
	assign selStat = (avsAddress == `CRCC_REG_STAT);
	assign selIrq = (avsAddress == `CRCC_REG_IRQ);
	assign selMask = (avsAddress == `CRCC_REG_MASK);
	assign selNone = ~(selCtrl | selStat | selIrq | selMask);

	// Avalon handshake: one wait cycle, answer stands one cycle
	// Waitrequest idles high, so no request finishes unseen
	always @(posedge clock) begin
		if (srst) begin
			busy_q <= 1'b0;
			avsWaitRequest <= 1'b1;
			avsResponse <= 1'b0;
		end else if (accept) begin
			busy_q <= 1'b1;
			avsWaitRequest <= 1'b0;
			// Unmapped address: slave error, write dropped
			avsResponse <= selNone;
		end else begin
			// Busy blocks a second take of a request still held
			busy_q <= 1'b0;
			avsWaitRequest <= 1'b1;
			avsResponse <= 1'b0;
		end
	end

	// Read data latched at acceptance; unmapped reads zero
	// Held between accesses; only valid while waitrequest is low
	always @(posedge clock) begin
		if (srst) begin
			avsReadData <= 32'h00000000;
		end else if (accept) begin
			case (avsAddress)
			`CRCC_REG_CTRL: begin
				avsReadData <= {24'h000000, ctrl_q};
			end
			`CRCC_REG_STAT: begin
				// Status word: on, muted, key, then display code
				avsReadData <= {24'h000000, 2'h0, statusDisplay, talkbackKey,
					outputsMuted, onStatus};
			end
			`CRCC_REG_IRQ: begin
				avsReadData <= {28'h0000000, irqStat_q};
			end
			`CRCC_REG_MASK: begin
				avsReadData <= {28'h0000000, irqMask_q};
			end
			default: begin
				avsReadData <= 32'h00000000;
			end
			endcase
		end
	end

	// Control register; local on and off bits are one-cycle strobes
	always @(posedge clock) begin
		if (srst) begin
			ctrl_q <= 8'h00;
			localOnReq <= 1'b0;
			localOffReq <= 1'b0;
		end else if (wrAccept & selCtrl) begin
			ctrl_q <= avsWriteData[7:0];
			localOnReq <= avsWriteData[`CRCC_CTL_LOCAL_ON];
			localOffReq <= avsWriteData[`CRCC_CTL_LOCAL_OFF];
		end else begin
			// A strobe clears itself, so no later write replays it
			localOnReq <= 1'b0;
			localOffReq <= 1'b0;
		end
	end

	// Sticky status; an event in the clearing cycle is kept,
	// so software never loses an edge it has not yet seen
	always @(posedge clock) begin
		if (srst) begin
			irqStat_q <= {`CRCC_NIRQ{1'b0}};
		end else if (wrAccept & selIrq) begin
			irqStat_q <= (irqStat_q & ~avsWriteData[`CRCC_NIRQ-1:0]) | events;
		end else begin
			irqStat_q <= irqStat_q | events;
		end
	end

	// Interrupt mask, same layout as the status
	// Masking hides a bit from the pin, not from the status
	always @(posedge clock) begin
		if (srst) begin
			irqMask_q <= {`CRCC_NIRQ{1'b0}};
		end else if (wrAccept & selMask) begin
			irqMask_q <= avsWriteData[`CRCC_NIRQ-1:0];
		end
	end

	// Level interrupt, one cycle behind the status
	// Registered so the pin never glitches on decode
	always @(posedge clock) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStat_q & irqMask_q);
		end
	end
endmodule // crcc_channel

// [crcc_channel_properties.sv]
// Port assertions for the channel control block
`timescale 1ns/1ps
`include "crcc_defs.vh"
module crcc_channel_properties (
	input wire clock,
	input wire srst,
	input wire avsWaitRequest,
	input wire onStatus,
	input wire onLamp,
	input wire offLamp,
	input wire startPulse,
	input wire stopPulse,
	input wire talkbackKey,
	input wire [2:0] statusDisplay,
	input wire [2:0] feedLeftSel,
	input wire feedMinusSelf,
	input wire outputsMuted,
	input wire sourceToTalkback
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// Steps of a remote talk
	sequence talkStart; !sourceToTalkback ##1 sourceToTalkback; endsequence
	sequence talkEnd; sourceToTalkback ##1 !sourceToTalkback; endsequence
	// One lit and one dark phase; bounds suit the short bench flash
	sequence keyBlink; ##[1:40] talkbackKey ##[1:40] !talkbackKey; endsequence
	a_wait_one_cycle: assert property (!avsWaitRequest |=> avsWaitRequest)
		else $error("waitrequest low two cycles");
	a_lamps_exclusive: assert property (onLamp |-> !offLamp)
		else $error("on and off lamps together");
	a_start_after_on: assert property (startPulse |-> onStatus && !$past(onStatus))
		else $error("start pulse without turn on");
	a_stop_after_off: assert property (stopPulse |-> !onStatus && $past(onStatus))
		else $error("stop pulse without turn off");
	a_talk_mutes: assert property (talkStart |-> outputsMuted && talkbackKey)
		else $error("talk not muting");
	a_talk_shown: assert property (statusDisplay == `CRCC_DISP_TALK |-> sourceToTalkback)
		else $error("TALK shown without talk");
	a_key_flashes: assert property (talkEnd |-> keyBlink)
		else $error("key not flashing");
	a_mute_shown: assert property (statusDisplay == `CRCC_DISP_MUTE |-> outputsMuted)
		else $error("MUTE shown unmuted");
	a_minus_self: assert property (feedMinusSelf |-> feedLeftSel == `CRCC_SRC_PGM1 && onStatus)
		else $error("minus self off program one");
endmodule // crcc_channel_properties
bind crcc_channel crcc_channel_properties i_props (.clock(clock), .srst(srst),
	.avsWaitRequest(avsWaitRequest), .onStatus(onStatus), .onLamp(onLamp), .offLamp(offLamp),
	.startPulse(startPulse), .stopPulse(stopPulse), .talkbackKey(talkbackKey),
	.statusDisplay(statusDisplay), .feedLeftSel(feedLeftSel), .feedMinusSelf(feedMinusSelf),
	.outputsMuted(outputsMuted), .sourceToTalkback(sourceToTalkback));

// [crcc_panel_model.sv]
// Remote logic panel: command levels out, lamp state in
`timescale 1ns/1ps
module crcc_panel_model (
	input wire clock,
	input wire [5:0] press,
	input wire onLamp,
	output reg [5:0] remoteCmd,
	output reg seenOn
);
	initial remoteCmd = 6'h00;
	always @(posedge clock) begin
		remoteCmd <= press;
	end
	always @(posedge clock) begin
		seenOn <= onLamp;
	end
endmodule // crcc_panel_model

// [crcc_channel_tb.sv]
// Self-checking bench for the caller and codec channel block
`timescale 1ns/1ps
`include "crcc_defs.vh"
module crcc_channel_tb;
	logic clock = 0, srst = 1, avsRead = 0, avsWrite = 0, operatorTalk = 0, rsp;
	logic [3:0] avsAddress = 4'h0;
	logic [31:0] avsWriteData = 32'h0, rd;
	logic [5:0] press = 6'h00;
	wire [5:0] remoteCmd;
	wire [31:0] avsReadData;
	wire [2:0] statusDisplay, feedLeftSel, feedRightSel;
	wire avsWaitRequest, avsResponse, onLamp, offLamp, previewLamp, onStatus, seenOn, irq;
	wire startPulse, stopPulse, talkbackKey, feedMinusSelf, outputsMuted, sourceToTalkback;
	int failures = 0, checks_done = 0, starts = 0, stops = 0;
	// Short counts keep the run brief
	crcc_channel #(.DEB_CYC(29'h4), .FLASH_CYC(29'h64), .BLINK_CYC(29'hA)) i_dut (.clock(clock),
		.srst(srst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse), .remoteCmd(remoteCmd),
		.operatorTalk(operatorTalk), .onLamp(onLamp), .offLamp(offLamp),
		.previewLamp(previewLamp), .onStatus(onStatus), .startPulse(startPulse),
		.stopPulse(stopPulse), .talkbackKey(talkbackKey), .statusDisplay(statusDisplay),
		.feedLeftSel(feedLeftSel), .feedRightSel(feedRightSel), .feedMinusSelf(feedMinusSelf),
		.outputsMuted(outputsMuted), .sourceToTalkback(sourceToTalkback), .irq(irq));
	crcc_panel_model i_panel (.clock(clock), .press(press), .onLamp(onLamp),
		.remoteCmd(remoteCmd), .seenOn(seenOn));
	// Clock and pulse counters
	always #5 clock = ~clock;
	always @(posedge clock) begin
		starts <= starts + startPulse;
		stops <= stops + stopPulse;
	end
	task end_sim;
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			failures++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	// Avalon access; holds until waitrequest is seen low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		@(posedge clock);
		while (avsWaitRequest !== 1'b0 && n < 50) begin
			n++;
			@(posedge clock);
		end
		chk(n < 50, "bus timeout");
		rd = avsReadData;
		rsp = avsResponse;
		avsWrite <= 0;
		avsRead <= 0;
		@(posedge clock);
	endtask
	// Pin to lamp latency is fixed, so a fixed wait covers it
	task cmd(input logic [5:0] v);
		press <= v;
		repeat (16) @(posedge clock);
	endtask
	task t_regs;
		bus(0, `CRCC_REG_CTRL, 0);
		chk(rd === 32'h0 && rsp === 1'b0, "ctrl reset");
		bus(1, 4'h2, 32'hFF);
		chk(rsp === 1'b1, "unmapped");
	endtask
	task t_caller;
		bus(1, `CRCC_REG_CTRL, 32'h88);
		chk(feedLeftSel === `CRCC_SRC_TB && talkbackKey === 1'b1, "auto off");
		chk(statusDisplay === `CRCC_DISP_TB && offLamp === 1'b1, "off shown");
		cmd(6'h01);
		chk(onStatus === 1'b1 && seenOn === 1'b1 && starts == 1, "remote on");
		chk(feedLeftSel === `CRCC_SRC_PGM1 && feedMinusSelf === 1'b1, "minus self");
		chk(statusDisplay === `CRCC_DISP_PGM, "on shown");
		cmd(6'h05);
		chk(previewLamp === 1'b1 && onLamp === 1'b1, "preview");
		for (int m = 0; m < 4; m++) begin
			bus(1, `CRCC_REG_CTRL, m << 1);
			chk(feedLeftSel === m[2:0] && feedMinusSelf === 1'b0, "fixed bus");
		end
		cmd(6'h02);
		chk(onStatus === 1'b0 && offLamp === 1'b1 && stops == 0, "remote off");
		bus(1, `CRCC_REG_CTRL, 32'h80);
		cmd(6'h01);
		chk(starts == 2 && onLamp === 1'b1, "pulse on");
		cmd(6'h02);
		chk(stops == 1 && offLamp === 1'b1, "pulse off");
		cmd(6'h00);
		bus(1, `CRCC_REG_CTRL, 32'h90);
		repeat (2) @(posedge clock);
		bus(0, `CRCC_REG_STAT, 0);
		chk(rd === {24'h000000, 2'h0, `CRCC_DISP_PGM, 3'h1}, "local on");
		bus(1, `CRCC_REG_CTRL, 32'hA0);
		repeat (2) @(posedge clock);
		chk(onStatus === 1'b0 && stops == 2 && starts == 3, "local off");
	endtask
	task t_codec;
		int n;
		bus(1, `CRCC_REG_MASK, 32'h04);
		bus(1, `CRCC_REG_CTRL, 32'h01);
		cmd(6'h01);
		chk(onStatus === 1'b1 && feedRightSel === `CRCC_SRC_PGM1, "codec on");
		cmd(6'h08);
		chk(outputsMuted === 1'b1 && sourceToTalkback === 1'b1, "talk mutes");
		chk(talkbackKey === 1'b1 && statusDisplay === `CRCC_DISP_TALK, "talk shown");
		chk(irq === 1'b1 && feedRightSel !== `CRCC_SRC_TB, "talk irq");
		bus(1, `CRCC_REG_IRQ, 32'h04);
		@(posedge clock);
		chk(irq === 1'b0, "irq cleared");
		press <= 6'h00;
		n = 0;
		repeat (40) begin
			@(posedge clock);
			n += (talkbackKey === 1'b0);
		end
		chk(outputsMuted === 1'b0 && n > 5 && n < 30, "key flash");
		repeat (150) @(posedge clock);
		chk(talkbackKey === 1'b0, "flash over");
		cmd(6'h10);
		chk(outputsMuted === 1'b1 && statusDisplay === `CRCC_DISP_MUTE, "mute");
		chk(irq === 1'b0, "masked irq");
		cmd(6'h00);
		chk(outputsMuted === 1'b0, "unmute");
		bus(1, `CRCC_REG_CTRL, 32'h41);
		operatorTalk <= 1;
		repeat (3) @(posedge clock);
		chk(feedLeftSel === `CRCC_SRC_TB && feedRightSel === `CRCC_SRC_PGM2, "op talk");
		operatorTalk <= 0;
		repeat (3) @(posedge clock);
		chk(feedLeftSel === `CRCC_SRC_PGM2 && feedRightSel === `CRCC_SRC_PGM2, "pgm2");
	endtask
	// Main sequence after a four-cycle reset
	initial begin
		repeat (4) @(posedge clock);
		srst <= 0;
		@(posedge clock);
		t_regs;
		t_caller;
		t_codec;
		end_sim;
	end
	// Watchdog well beyond the expected run
	initial begin
		#200000;
		$display("MISMATCH %0t watchdog expired", $time);
		failures++;
		end_sim;
	end
endmodule // crcc_channel_tb
